// >>> core/spx_eeprom.sv
// spx_eeprom.sv: command and data path of a 64-kbit serial EEPROM on an spi link, modes 0 and 3
// assumes i_sck stops outside frames and chip select stays high for at least 4 core clocks
// Notes on behaviour
// R01: write accepts up to 64 data bytes into the page buffer
// R02: page load advances only in-page offset; wrap overwrites earlier bytes
// R03: end of any write cycle clears the write enable latch
// R04: host sends read opcode then sixteen address bits msb first
// R05: status write alters only bits 2, 3 and 7
// R06: write protect low with pin enable set refuses status writes
// R07: protect falling during a status write frame aborts it; started cycles continue
// R08: pin enable clear means the protect pin is ignored
// R09: read data starts right after the last address bit
// R10: sequential read advances the pointer each byte
// R11: pointer wraps from top address to zero; read goes on forever
// R12: chip select high ends the read and stops output
// R13: status bits shift out right after the status read opcode
// R14: status read works anytime, also during a write cycle
// R15: host lowers pause only while clock is low
// R16: host keeps chip select low throughout a pause
// R17: paused: output off, input ignored, command state kept
// R18: host raises pause only while clock is low
// R19: power up with writes disabled; enable command needed first
// R20: write starts only on chip select rise after exact bit count
// R21: array commands during a write cycle are ignored
// R22: unknown opcode ignored, output stays off until deselect
// R23: only the low thirteen address bits are used
// R24: status layout pin enable, zeros, guard high, guard low, latch, busy
// R25: busy reads one during the write cycle, read only
// R26: enable and disable commands set and clear the latch; writes need it
`timescale 1ns/1ns
`include "spx_map.svh"
module spx_eeprom #(
	parameter int WCYC = `SPX_WCYC_CYC,
	parameter int AW = 13,
	parameter int PW = 6
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_sck,
	input wire spx_pkg::spx_pins_s i_pins,
	output logic o_so,
	output logic o_so_oe,
	output logic o_busy
);
	import spx_pkg::*;
	localparam int PB = 1 << PW;

	////////////////////////////////////////////////////////////////////////
	// shared storage: array written by core, read by link while idle
	logic [7:0] mem [0:(1<<AW)-1];
	logic [7:0] pbuf [0:PB-1];
	logic [7:0] stat;
	logic busy_r, wlatch_r, pinen_r;
	logic [1:0] bg_r;
	// R24: status layout
	assign stat = {pinen_r, 3'h0, bg_r, wlatch_r, busy_r};

	////////////////////////////////////////////////////////////////////////
	// link domain; chip select high clears the frame start and drive flags and the serial output
	logic lk_rst_n;
	assign lk_rst_n = i_rst_n & ~i_pins.cs_n;
	spx_lk_e lk_st_r, lk_st_nxt;
	logic lk_go_r, lk_drv_r, lk_drv_nxt;
	logic [2:0] lk_bit_r, lk_bit_nxt;
	logic [6:0] lk_byt_r, lk_byt_nxt;
	logic [7:0] lk_op_r, lk_op_nxt, lk_sh_r, lk_sh_nxt, lk_tx_r, lk_tx_nxt, lk_sr_r, lk_sr_nxt, inb;
	logic [AW-1:0] lk_adr_r, lk_adr_nxt;
	logic [PW-1:0] lk_off_r, lk_off_nxt;
	logic [PB-1:0] lk_msk_r, lk_msk_nxt;
	logic lk_pw;

	// next-state of the link shifter, one step per sck rise
	always_comb begin
		spx_lk_e st;
		logic [6:0] byt;
		st = lk_go_r ? lk_st_r : SPX_OPC;
		byt = lk_go_r ? lk_byt_r : 7'h00;
		lk_bit_nxt = lk_go_r ? lk_bit_r + 3'h1 : 3'h1;
		inb = {lk_sh_r[6:0], i_pins.si};
		lk_sh_nxt = inb;
		lk_st_nxt = st;
		lk_byt_nxt = byt;
		lk_op_nxt = lk_op_r;
		lk_tx_nxt = lk_tx_r;
		lk_sr_nxt = lk_sr_r;
		lk_adr_nxt = lk_adr_r;
		lk_off_nxt = lk_off_r;
		lk_msk_nxt = lk_msk_r;
		lk_drv_nxt = lk_drv_r;
		lk_pw = 1'b0;
		if (lk_go_r && lk_bit_r == 3'h7) begin
			lk_byt_nxt = (byt == 7'h7F) ? byt : byt + 7'h01;
			unique case (st)
				SPX_OPC: begin
					lk_op_nxt = inb;
					lk_st_nxt = SPX_IDLE;
					// R21: array commands ignored while busy; mask kept for the running program
					if ((inb == `SPX_OP_READ || inb == `SPX_OP_WRITE) && !busy_r) begin
						lk_st_nxt = SPX_ADR;
						lk_msk_nxt = '0;
					end
					// R13: R14: status out right after opcode, even while busy
					if (inb == `SPX_OP_SRD) begin
						lk_st_nxt = SPX_STAT;
						lk_tx_nxt = stat;
						lk_drv_nxt = 1'b1;
					end
					if (inb == `SPX_OP_SWR)
						lk_st_nxt = SPX_WDAT;
					// R22: unknown opcode falls to idle, output stays off
				end
				SPX_ADR: begin
					// R23: upper three address bits dropped
					if (byt == 7'h01) begin
						lk_adr_nxt = {inb[AW-9:0], lk_adr_r[7:0]};
					end else begin
						lk_adr_nxt = {lk_adr_r[AW-1:8], inb};
						lk_off_nxt = inb[PW-1:0];
						lk_st_nxt = SPX_WDAT;
						// R09: first read byte ready for the next falling edge
						if (lk_op_r == `SPX_OP_READ) begin
							lk_tx_nxt = mem[{lk_adr_r[AW-1:8], inb}];
							lk_adr_nxt = {lk_adr_r[AW-1:8], inb} + AW'(1);
							lk_st_nxt = SPX_RDAT;
							lk_drv_nxt = 1'b1;
						end
					end
				end
				SPX_WDAT: begin
					if (lk_op_r == `SPX_OP_SWR) begin
						lk_sr_nxt = inb;
						lk_st_nxt = SPX_IDLE;
					end else begin
						// R01: R02: offset wraps inside the page
						lk_pw = 1'b1;
						lk_msk_nxt[lk_off_r] = 1'b1;
						lk_off_nxt = lk_off_r + PW'(1);
					end
				end
				SPX_RDAT: begin
					// R10: R11: pointer advances and wraps at the top
					lk_tx_nxt = mem[lk_adr_r];
					lk_adr_nxt = lk_adr_r + AW'(1);
				end
				SPX_STAT: lk_tx_nxt = stat;
				SPX_IDLE: lk_st_nxt = SPX_IDLE;
			endcase
		end
	end

	// R17: pause freezes every link register
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk_st_r <= SPX_IDLE;
			lk_bit_r <= 3'h0;
			lk_byt_r <= 7'h00;
			lk_op_r <= 8'h00;
			lk_sh_r <= 8'h00;
			lk_tx_r <= 8'h00;
			lk_sr_r <= 8'h00;
			lk_adr_r <= '0;
			lk_off_r <= '0;
			lk_msk_r <= '0;
		end else if (i_pins.hold_n) begin
			lk_st_r <= lk_st_nxt;
			lk_bit_r <= lk_bit_nxt;
			lk_byt_r <= lk_byt_nxt;
			lk_op_r <= lk_op_nxt;
			lk_sh_r <= lk_sh_nxt;
			lk_tx_r <= lk_tx_nxt;
			lk_sr_r <= lk_sr_nxt;
			lk_adr_r <= lk_adr_nxt;
			lk_off_r <= lk_off_nxt;
			lk_msk_r <= lk_msk_nxt;
		end
	end

	// page buffer holds no reset; the mask says which bytes are valid
	always_ff @(posedge i_sck) begin
		if (i_pins.hold_n && lk_pw)
			pbuf[lk_off_r] <= inb;
	end

	// R12: frame flags die with chip select
	always_ff @(posedge i_sck or negedge lk_rst_n) begin
		if (!lk_rst_n) begin
			lk_go_r <= 1'b0;
			lk_drv_r <= 1'b0;
		end else if (i_pins.hold_n) begin
			lk_go_r <= 1'b1;
			lk_drv_r <= lk_drv_nxt;
		end
	end

	// serial out changes on the falling edge, msb first
	always_ff @(negedge i_sck or negedge lk_rst_n) begin
		if (!lk_rst_n)
			o_so <= 1'b0;
		else if (i_pins.hold_n)
			o_so <= lk_tx_r[~lk_bit_r];
	end

	////////////////////////////////////////////////////////////////////////
	// core domain synchronisers
	logic [1:0] cs_q, wp_q, hd_q, dv_q;
	logic cs_d_r, wp_d_r, rise, wpf_r, wpf_nxt;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_q <= 2'h3;
			wp_q <= 2'h3;
			hd_q <= 2'h3;
			dv_q <= 2'h0;
			cs_d_r <= 1'b1;
			wp_d_r <= 1'b1;
		end else begin
			cs_q <= {cs_q[0], i_pins.cs_n};
			wp_q <= {wp_q[0], i_pins.wp_n};
			hd_q <= {hd_q[0], i_pins.hold_n};
			dv_q <= {dv_q[0], lk_drv_r};
			cs_d_r <= cs_q[1];
			wp_d_r <= wp_q[1];
		end
	end
	assign rise = cs_q[1] & ~cs_d_r;

	////////////////////////////////////////////////////////////////////////
	// write control: commit on chip select rise, then the timed cycle
	logic [31:0] tmr_r, tmr_nxt;
	logic kst_r, kst_nxt, busy_nxt, wlatch_nxt, pinen_nxt, oe_nxt, wok;
	logic [1:0] bg_nxt;
	logic [7:0] srv_r, srv_nxt;
	logic [AW-1:0] wa;
	logic [PW-1:0] pg_i;
	// R06: R08: pin only counts when the enable bit is set
	assign wok = !(pinen_r && !wp_q[1]) && !wpf_r;
	assign pg_i = tmr_r[PW-1:0];
	assign wa = {lk_adr_r[AW-1:PW], pg_i};

	always_comb begin
		busy_nxt = busy_r;
		tmr_nxt = tmr_r;
		kst_nxt = kst_r;
		wlatch_nxt = wlatch_r;
		pinen_nxt = pinen_r;
		bg_nxt = bg_r;
		srv_nxt = srv_r;
		// R07: protect falling inside a frame is remembered until its end
		// only a falling pin counts, and only while the pin is enabled
		wpf_nxt = rise ? 1'b0 : (wpf_r | (!cs_q[1] && pinen_r && wp_d_r && !wp_q[1]));
		// R12: R17: R22: drive only while selected, unpaused and in an output state
		oe_nxt = !cs_q[1] && hd_q[1] && dv_q[1];
		if (busy_r) begin
			tmr_nxt = tmr_r + 32'h1;
			if (tmr_r == 32'(WCYC - 1)) begin
				// R03: R25: cycle end drops busy and the latch
				busy_nxt = 1'b0;
				wlatch_nxt = 1'b0;
				if (kst_r) begin
					// R05: only bits 7, 3, 2 taken
					pinen_nxt = srv_r[`SPX_ST_PEN];
					bg_nxt = {srv_r[`SPX_ST_BGH], srv_r[`SPX_ST_BGL]};
				end
			end
		end else if (rise && lk_bit_r == 3'h0) begin
			// R20: exact bit count checked at the rising chip select
			// R26: enable and disable need exactly one byte
			if (lk_op_r == `SPX_OP_WENA && lk_byt_r == 7'h01)
				wlatch_nxt = 1'b1;
			if (lk_op_r == `SPX_OP_WDIS && lk_byt_r == 7'h01)
				wlatch_nxt = 1'b0;
			if (lk_op_r == `SPX_OP_SWR && lk_byt_r == 7'h02 && wlatch_r && wok) begin
				busy_nxt = 1'b1;
				kst_nxt = 1'b1;
				tmr_nxt = 32'h0;
				srv_nxt = lk_sr_r;
			end
			if (lk_op_r == `SPX_OP_WRITE && lk_byt_r >= 7'h04 && wlatch_r) begin
				busy_nxt = 1'b1;
				kst_nxt = 1'b0;
				tmr_nxt = 32'h0;
			end
		end
	end

	// R19: power-up leaves the latch clear and the device idle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_r <= 1'b0;
			tmr_r <= 32'h0;
			kst_r <= 1'b0;
			wlatch_r <= 1'b0;
			pinen_r <= 1'(`SPX_SR_RST >> `SPX_ST_PEN);
			bg_r <= 2'h0;
			srv_r <= `SPX_SR_RST;
			wpf_r <= 1'b0;
			o_so_oe <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			tmr_r <= tmr_nxt;
			kst_r <= kst_nxt;
			wlatch_r <= wlatch_nxt;
			pinen_r <= pinen_nxt;
			bg_r <= bg_nxt;
			srv_r <= srv_nxt;
			wpf_r <= wpf_nxt;
			o_so_oe <= oe_nxt;
			o_busy <= busy_nxt;
		end
	end

	// page program: one loaded byte per core clock, guarded blocks skipped
	always_ff @(posedge i_core_clk) begin
		if (busy_r && !kst_r && tmr_r < 32'(PB) && lk_msk_r[pg_i] &&
				!(bg_r == 2'h3 || (bg_r == 2'h2 && wa >= `SPX_HALF_BASE) ||
				(bg_r == 2'h1 && wa >= `SPX_QTR_BASE)))
			mem[wa] <= pbuf[pg_i];
	end

	////////////////////////////////////////////////////////////////////////
	// checks on the core side, plus one on the link clock for the read pointer
	// R03
	AST_LATCH_CLR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) $fell(busy_r) |-> !wlatch_r) // R03
		else $error("latch still set after write cycle");
	// R20
	AST_BUSY_CAUSE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(busy_r) |-> $past(rise)) // R20
		else $error("write cycle began without chip select rise");
	// R26
	AST_LATCH_SET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(wlatch_r) |-> $past(rise) && $past(lk_op_r) == `SPX_OP_WENA) // R26
		else $error("latch set by something other than enable command");
	// R06
	AST_WP_REFUSE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		rise && !busy_r && pinen_r && !wp_q[1] && lk_op_r == `SPX_OP_SWR |=> !busy_r) // R06
		else $error("status write taken while protected");
	// R05
	AST_SR_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) stat[6:4] == 3'h0) // R05
		else $error("status bits 6 to 4 not zero");
	// R25
	sequence s_cyc;
		$rose(busy_r) ##1 busy_r [*8];
	endsequence
	AST_BUSY_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) s_cyc |-> o_busy) // R25
		else $error("busy dropped too early");
	// R21
	AST_NO_REARM: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		busy_r && rise |=> tmr_r == $past(tmr_r) + 32'h1) // R21
		else $error("write cycle disturbed by new frame");
	// R12
	AST_OE_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) cs_q[1] |=> !o_so_oe) // R12
		else $error("output driven while deselected");
	// R11
	AST_RD_WRAP: assert property (@(posedge i_sck) disable iff (!lk_rst_n)
		i_pins.hold_n && lk_go_r && lk_st_r == SPX_RDAT && lk_bit_r == 3'h7 |=> lk_adr_r == $past(lk_adr_r) + AW'(1)) // R11
		else $error("read pointer did not advance");
endmodule // spx_eeprom

// >>> shared/spx_map.svh
// spx_map.svh: opcodes, status bit positions, sizes and timing of the serial EEPROM core
// assumes a 10 MHz core clock; included by bare name
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH
`define SPX_OP_WENA 8'h06
`define SPX_OP_WDIS 8'h04
`define SPX_OP_SRD 8'h05
`define SPX_OP_SWR 8'h01
`define SPX_OP_READ 8'h03
`define SPX_OP_WRITE 8'h02
`define SPX_ST_PEN 7
`define SPX_ST_BGH 3
`define SPX_ST_BGL 2
`define SPX_ST_LATCH 1
`define SPX_ST_BSY 0
`define SPX_SR_MASK 8'h8C
`define SPX_SR_RST 8'h00
`define SPX_QTR_BASE 13'h1800
`define SPX_HALF_BASE 13'h1000
`define SPX_CLK_MHZ 10
`define SPX_WCYC_US 5000
`define SPX_WCYC_CYC (`SPX_WCYC_US * `SPX_CLK_MHZ)
`endif

// >>> shared/spx_pkg.sv
// spx_pkg.sv: types shared by the serial EEPROM core
// assumes nothing beyond the map header
package spx_pkg;
	typedef enum logic [5:0] {
		SPX_OPC = 6'h01, SPX_ADR = 6'h02, SPX_WDAT = 6'h04,
		SPX_RDAT = 6'h08, SPX_STAT = 6'h10, SPX_IDLE = 6'h20
	} spx_lk_e;
	// pins of the serial link as one bundle
	typedef struct packed {
		logic cs_n;
		logic si;
		logic hold_n;
		logic wp_n;
	} spx_pins_s;
endpackage

// >>> test/spx_eeprom_test.sv
// spx_eeprom_test.sv: self-checking bench for the serial eeprom core
// assumes the host model drives all link pins; short write cycle for run time
`timescale 1ns/1ns
`include "spx_map.svh"
module spx_eeprom_test;
	import spx_pkg::*;
	localparam int WCYC = 100;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic sck;
	spx_pins_s pins;
	logic so;
	logic so_oe;
	logic busy;
	logic oe_seen = 1'b0;
	int bad_count = 0;
	int total_checks = 0;
	logic [7:0] exp_pg [64];
	logic [7:0] wq [$];
	always #50 i_core_clk = ~i_core_clk;
	spx_eeprom #(.WCYC(WCYC)) i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sck(sck), .i_pins(pins),
		.o_so(so), .o_so_oe(so_oe), .o_busy(busy));
	spx_host_model i_host (.i_core_clk(i_core_clk), .i_so(so), .o_sck(sck), .o_pins(pins));
	// remember any drive on the output, cleared by the sequence
	always @(posedge i_core_clk) begin
		if (so_oe === 1'b1)
			oe_seen <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] b [$], input int nrx, input int cut = 0, input int pause_at = -1);
		i_host.tx = b;
		i_host.frame(nrx, cut, pause_at);
	endtask
	task automatic status(input logic [7:0] exp);
		send({`SPX_OP_SRD}, 1);
		check(i_host.rx[0], exp);
	endtask
	// bounded wait, a hang counts as a mismatch
	task automatic wait_ready();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 500) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n == 500) begin
			bad_count++;
			end_of_test();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_core_clk);
		// latch control and power-up state
		status(8'h00);
		send({`SPX_OP_WRITE, 8'h00, 8'h00, 8'h11}, 0);
		check({7'h00, busy}, 8'h00);
		send({`SPX_OP_WENA}, 0);
		status(8'h02);
		send({`SPX_OP_WDIS}, 0);
		status(8'h00);
		$display("test latch done");
		// 66 bytes into one page from offset 60, upper address bits junk
		send({`SPX_OP_WENA}, 0);
		wq = {`SPX_OP_WRITE, 8'hE0, 8'h7C};
		for (int k = 0; k < 66; k++) begin
			wq.push_back(k[7:0]);
			exp_pg[(k + 60) % 64] = k[7:0];
		end
		send(wq, 0);
		check({7'h00, busy}, 8'h01);
		status(8'h03);
		oe_seen = 1'b0;
		send({`SPX_OP_READ, 8'h00, 8'h40}, 4);
		check({7'h00, oe_seen}, 8'h00);
		wait_ready();
		status(8'h00);
		send({`SPX_OP_READ, 8'h00, 8'h40}, 64);
		for (int k = 0; k < 64; k++)
			check(i_host.rx[k], exp_pg[k]);
		$display("test page done");
		// top-to-zero wrap with a pause inside the first read byte
		send({`SPX_OP_WENA}, 0);
		send({`SPX_OP_WRITE, 8'h1F, 8'hFF, 8'hA5}, 0);
		wait_ready();
		send({`SPX_OP_WENA}, 0);
		send({`SPX_OP_WRITE, 8'h00, 8'h00, 8'h5A, 8'h3C}, 0);
		wait_ready();
		send({`SPX_OP_READ, 8'hFF, 8'hFF}, 3, 0, 30);
		check(i_host.rx[0], 8'hA5);
		check(i_host.rx[1], 8'h5A);
		check(i_host.rx[2], 8'h3C);
		$display("test wrap done");
		// short frame and unknown opcode
		send({`SPX_OP_WENA}, 0);
		send({`SPX_OP_WRITE, 8'h00, 8'h00, 8'h77}, 0, 1);
		check({7'h00, busy}, 8'h00);
		oe_seen = 1'b0;
		send({8'hFF}, 4);
		check({7'h00, oe_seen}, 8'h00);
		status(8'h02);
		$display("test refuse done");
		// status writes under the protect pin
		send({`SPX_OP_SWR, 8'hFF}, 0);
		check({7'h00, busy}, 8'h01);
		wait_ready();
		status(8'h8C);
		i_host.set_wp(1'b0);
		send({`SPX_OP_WENA}, 0);
		send({`SPX_OP_SWR, 8'h00}, 0);
		check({7'h00, busy}, 8'h00);
		status(8'h8E);
		i_host.set_wp(1'b1);
		send({`SPX_OP_SWR, 8'h00}, 0);
		wait_ready();
		status(8'h00);
		i_host.set_wp(1'b0);
		send({`SPX_OP_WENA}, 0);
		send({`SPX_OP_SWR, 8'h0C}, 0);
		wait_ready();
		status(8'h0C);
		$display("test status done");
		end_of_test();
	end
endmodule // spx_eeprom_test

// >>> test/spx_host_model.sv
// spx_host_model.sv: host spi controller, mode 0, for the serial eeprom core
// assumes core clock for frame alignment; link clock 12 ns, parked low outside frames
`timescale 1ns/1ns
module spx_host_model (
	input wire logic i_core_clk,
	input wire logic i_so,
	output logic o_sck,
	output spx_pkg::spx_pins_s o_pins
);
	import spx_pkg::*;
	logic [7:0] tx [$];
	logic [7:0] rx [$];
	////////////////////////////////////////////////////////////////
	// idle: deselected, clock still, pause released
	initial begin
		o_sck = 1'b0;
		o_pins = '{cs_n: 1'b1, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
	end
	// protect pin moves off the core sampling edge
	task automatic set_wp(input logic v);
		@(negedge i_core_clk);
		o_pins.wp_n = v;
	endtask
	// one frame: tx msb first minus cut tail bits, then nrx bytes read back
	task automatic frame(input int nrx, input int cut, input int pause_at);
		int n;
		logic [7:0] b;
		n = tx.size() * 8 - cut;
		b = 8'h00;
		rx = {};
		@(negedge i_core_clk);
		o_pins.cs_n = 1'b0;
		for (int i = 0; i < n + nrx * 8; i++) begin
			o_pins.si = (i < n) ? tx[i / 8][7 - i % 8] : ~o_pins.si;
			#6;
			if (i == pause_at) begin
				o_pins.hold_n = 1'b0;
				repeat (4) begin
					#6 o_sck = 1'b1;
					o_pins.si = ~o_pins.si;
					#6 o_sck = 1'b0;
				end
				#6 o_pins.hold_n = 1'b1;
				#6;
			end
			o_sck = 1'b1;
			if (i >= n)
				b = {b[6:0], i_so};
			if (i >= n && (i - n) % 8 == 7)
				rx.push_back(b);
			#6;
			o_sck = 1'b0;
		end
		#6;
		o_pins.cs_n = 1'b1;
		o_pins.si = ~o_pins.si; // released line must not look held
		repeat (5) @(negedge i_core_clk);
		tx = {};
	endtask
endmodule // spx_host_model
